// file: src/drv_cal_pkg.sv
// How it works
// - Hardware reset starts auto calibration, 49 ohm target
// - Targets 38 to 80 ohm, separate PMOS/NMOS
// - Page 0x000A shows calibration control/status
// - Restart bit 15 self clears, then calibration
// - Bit 14 reads one when calibration done
// - Five-bit PMOS 12:8, NMOS 4:0 strengths
// - Finished calibration loads result strength codes
// - Latch bit 6 applies written strength, self clears
// - Select bit 5 picks PMOS or NMOS
// - Page 0x000B holds 3-bit PMOS/NMOS targets
// - Target code 011 both aims near 54 ohm
// - CRS, COL, RX_ER drive strength stays fixed
package drv_cal_pkg;

	// ---------------------------------------------
	// Register map (byte address = index * 4)
	// ---------------------------------------------
	localparam logic [7:0] IDX_PAGE = 8'h1d;
	localparam logic [7:0] IDX_DATA = 8'h1e;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
	localparam logic [7:0] IDX_SOFT_RESET = 8'h22;
	localparam logic [15:0] PAGE_CAL_CTRL = 16'h000a;
	localparam logic [15:0] PAGE_CAL_TARGET = 16'h000b;

	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int BIT_RESTART = 15;
	localparam int BIT_DONE = 14;
	localparam int BIT_LATCH = 6;
	localparam int BIT_SELECT = 5;
	localparam int PMOS_LSB = 8;
	localparam int NMOS_LSB = 0;
	localparam int TGT_P_LSB = 4;
	localparam int TGT_N_LSB = 0;

	// ---------------------------------------------
	// Reset values and timing
	// ---------------------------------------------
	localparam logic [15:0] PAGE_RESET = 16'h0000;
	localparam logic [2:0] TARGET_RESET = 3'h2;
	localparam logic [4:0] STRENGTH_RESET = 5'h10;
	localparam logic [4:0] FIXED_STRENGTH = 5'h10;
	localparam int STEP_CYCLES = 4;

	typedef enum {CAL_IDLE, CAL_PEND, CAL_RUN, CAL_DONE} cal_state_t;

endpackage

// file: src/drv_cal.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module drv_cal #(
	parameter int CODE_WIDTH = 5
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [CODE_WIDTH-1:0] compMeasure,
	output logic [CODE_WIDTH-1:0] pmosCode,
	output logic [CODE_WIDTH-1:0] nmosCode,
	output logic [CODE_WIDTH-1:0] fixedPinCode,
	output logic calBusy,
	output logic irq
);
	import drv_cal_pkg::*;

	// Elaboration guard: the engine, the register view and the search
	// arithmetic are all written for five-bit driver codes
	if (CODE_WIDTH != 5) begin : gBadWidth
		$error("drv_cal serves 5-bit codes only");
	end

	// ---------------------------------------------
	// Bus decode
	// ---------------------------------------------
	logic access;
	logic wrEn;
	logic rdEn;
	logic [9:0] idx;
	// Register fields, kept through anything but hardware reset
	logic [15:0] page;
	logic [2:0] tgtP;
	logic [2:0] tgtN;
	logic [4:0] strP;
	logic [4:0] strN;
	logic selBit;
	logic doneFlag;
	logic restartBit;
	logic [1:0] irqStatus;
	logic [1:0] irqMask;
	// Engine state
	logic [3:0] stepCnt;
	logic [4:0] searchP;
	logic [4:0] searchN;
	logic calFinish;
	cal_state_t state;

	// Access phase qualifiers; the slave never stalls, so every access
	// phase completes on its first edge and errors are never signalled
	assign access = psel && penable;
	assign wrEn = access && pwrite;
	assign rdEn = access && !pwrite;
	assign idx = paddr[11:2];
	assign pready = 1'b1; // Zero wait states
	assign pslverr = 1'b0;

	// Word index match; upper index bits must be zero, so no aliasing
	function automatic logic hit(input logic [9:0] a, input logic [7:0] r);
		hit = (a == {2'b00, r});
	endfunction

	// Paged writes: the page in force at the access edge picks the view
	logic ctrlWr;
	logic tgtWr;
	assign ctrlWr = wrEn && hit(idx, IDX_DATA) && page == PAGE_CAL_CTRL;
	assign tgtWr = wrEn && hit(idx, IDX_DATA) && page == PAGE_CAL_TARGET;

	// ---------------------------------------------
	// Page pointer
	// ---------------------------------------------
	// Soft reset leaves everything here alone on purpose; any 16-bit page
	// value is stored, unknown pages simply read back as zero
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			page <= PAGE_RESET;
		end else if (wrEn && hit(idx, IDX_PAGE)) begin
			page <= pwdata[15:0];
		end
	end

	// Targets, three bits each side; both are taken in one write, so
	// software changing one side must write the other back unchanged
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tgtP <= TARGET_RESET;
			tgtN <= TARGET_RESET;
		end else if (tgtWr) begin
			tgtP <= pwdata[TGT_P_LSB +: 3];
			tgtN <= pwdata[TGT_N_LSB +: 3];
		end
	end

	// Select bit kept as ordinary storage for read back; the latch
	// itself uses the select value of its own write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			selBit <= 1'b0;
		end else if (ctrlWr) begin
			selBit <= pwdata[BIT_SELECT];
		end
	end

	// Restart bit: set by write, clears once engine accepts it. The set
	// wins over the clear, so a restart written in the pending cycle or
	// during a run is held and served after the run in progress
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			restartBit <= 1'b0;
		end else if (ctrlWr && pwdata[BIT_RESTART]) begin
			restartBit <= 1'b1;
		end else if (state == CAL_PEND) begin
			restartBit <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Calibration engine
	// ---------------------------------------------
	// Successive approach toward the comparator's code; a target code
	// offsets the goal so 3'h2 maps to the default 49 ohm point and
	// 3'h3 a slightly weaker drive near 54 ohm. The goal is clamped to
	// the code range at both ends: a wrapped goal would drive the
	// search to the wrong extreme.
	// Limitation: the goal follows compMeasure every cycle, so a noisy
	// comparator lengthens a run; no run timeout is built in.
	function automatic logic [4:0] aim(input logic [4:0] m, input logic [2:0] t);
		logic [6:0] s;
		s = {2'b00, m} + {4'h0, TARGET_RESET} - {4'h0, t};
		if (s[6]) begin
			aim = 5'h00;
		end else if (s[5]) begin
			aim = 5'h1f;
		end else begin
			aim = s[4:0];
		end
	endfunction

	logic [4:0] goalP;
	logic [4:0] goalN;
	assign goalP = aim(compMeasure, tgtP);
	assign goalN = aim(compMeasure, tgtN);

	// Sequencer: hardware reset enters RUN directly, so no write is
	// needed for the first run; a restart passes one PEND cycle, in
	// which the restart bit and the done flag both clear, and a
	// restart seen during a run waits for that run to finish
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= CAL_RUN;
		end else begin
			unique case (state)
				CAL_IDLE, CAL_DONE: begin
					if (restartBit) state <= CAL_PEND;
				end
				CAL_PEND: state <= CAL_RUN;
				CAL_RUN: begin
					if (calFinish) state <= CAL_DONE;
				end
			endcase
		end
	end

	// Finish only on a step edge with both sides at their goal, so the
	// codes stored are ones the search has held for a full step
	assign calFinish = state == CAL_RUN && stepCnt == 4'(STEP_CYCLES - 1) &&
		searchP == goalP && searchN == goalN;
	assign calBusy = state == CAL_RUN || state == CAL_PEND;

	// One code unit toward the goal, never past it
	function automatic logic [4:0] stepToward(input logic [4:0] cur, input logic [4:0] goal);
		if (cur < goal) begin
			stepToward = cur + 5'h01;
		end else if (cur > goal) begin
			stepToward = cur - 5'h01;
		end else begin
			stepToward = cur;
		end
	endfunction

	// Step the search codes one unit every few cycles; the pause lets
	// the pad and comparator settle before the next decision
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stepCnt <= 4'h0;
			searchP <= STRENGTH_RESET;
			searchN <= STRENGTH_RESET;
		end else if (state == CAL_RUN) begin
			stepCnt <= (stepCnt == 4'(STEP_CYCLES - 1)) ? 4'h0 : stepCnt + 4'h1;
			if (stepCnt == 4'(STEP_CYCLES - 1)) begin
				searchP <= stepToward(searchP, goalP);
				searchN <= stepToward(searchN, goalN);
			end
		end else begin
			stepCnt <= 4'h0;
		end
	end

	// Done flag drops at run start, rises with stored codes; a run
	// after hardware reset starts with the flag already low
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			doneFlag <= 1'b0;
		end else if (calFinish) begin
			doneFlag <= 1'b1;
		end else if (state == CAL_PEND) begin
			doneFlag <= 1'b0;
		end
	end

	// Strength fields: engine result or manual latch. A finishing run
	// wins over a latch in the same cycle, since the run reports the
	// codes it was asked for; a later latch then replaces the selected side until the next run finishes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			strP <= STRENGTH_RESET;
			strN <= STRENGTH_RESET;
		end else if (calFinish) begin
			strP <= searchP;
			strN <= searchN;
		end else if (ctrlWr && pwdata[BIT_LATCH]) begin
			if (pwdata[BIT_SELECT]) begin
				strP <= pwdata[PMOS_LSB +: 5];
			end else begin
				strN <= pwdata[NMOS_LSB +: 5];
			end
		end
	end

	// Driver codes leave from flops; status pins never calibrated
	assign pmosCode = strP;
	assign nmosCode = strN;
	assign fixedPinCode = FIXED_STRENGTH;

	// ---------------------------------------------
	// Interrupts
	// ---------------------------------------------
	// Bit0 calibration done, bit1 manual latch; set wins over read-clear.
	// The clear comes from the access phase of a status read, one cycle
	// after the read data was captured, so an event set at the capture edge is lost unseen
	logic latchEvt;
	logic stRead;
	assign latchEvt = ctrlWr && pwdata[BIT_LATCH];
	assign stRead = rdEn && hit(idx, IDX_IRQ_STATUS);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			irqStatus <= 2'b00;
		end else begin
			irqStatus[0] <= calFinish || (irqStatus[0] && !stRead);
			irqStatus[1] <= latchEvt || (irqStatus[1] && !stRead);
		end
	end

	// Mask: a set bit lets the matching status bit reach irq
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			irqMask <= 2'b00;
		end else if (wrEn && hit(idx, IDX_IRQ_MASK)) begin
			irqMask <= pwdata[1:0];
		end
	end

	// Level interrupt, high while any unmasked status bit stands
	assign irq = |(irqStatus & irqMask);

	// ---------------------------------------------
	// Read data
	// ---------------------------------------------
	// Latch bit reads zero: it never holds state, and reserved bits
	// read zero whatever was written to them
	function automatic logic [15:0] pageView(input logic [15:0] p);
		if (p == PAGE_CAL_CTRL) begin
			pageView = {restartBit, doneFlag, 1'b0, strP, 1'b0, 1'b0, selBit, strN};
		end else if (p == PAGE_CAL_TARGET) begin
			pageView = {9'h000, tgtP, 1'b0, tgtN};
		end else begin
			pageView = 16'h0000;
		end
	endfunction

	// Read data captured in the setup cycle and held to the next read;
	// the access phase then returns a settled word
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			if (hit(idx, IDX_PAGE)) prdata <= {16'h0000, page};
			else if (hit(idx, IDX_DATA)) prdata <= {16'h0000, pageView(page)};
			else if (hit(idx, IDX_IRQ_STATUS)) prdata <= {30'h0, irqStatus};
			else if (hit(idx, IDX_IRQ_MASK)) prdata <= {30'h0, irqMask};
			else prdata <= 32'h00000000;
		end
	end

endmodule

// file: dv/drv_cal_chk.sv
`timescale 1ns/1ps
module drv_cal_chk #(
	parameter int CODE_WIDTH = 5
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [CODE_WIDTH-1:0] pmosCode,
	input wire logic [CODE_WIDTH-1:0] nmosCode,
	input wire logic [CODE_WIDTH-1:0] fixedPinCode,
	input wire logic calBusy
);
	import drv_cal_pkg::*;
	logic [15:0] pageSeen;
	logic dataWr;
	logic dataRd;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Shadow of the page pointer, so paged accesses can be told apart
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			pageSeen <= 16'h0000;
		else if (psel && penable && pwrite && paddr == 12'h074)
			pageSeen <= pwdata[15:0];
	end
	assign dataWr = psel && penable && pwrite && paddr == 12'h078 && pageSeen == PAGE_CAL_CTRL;
	assign dataRd = psel && penable && !pwrite && paddr == 12'h078 && pageSeen == PAGE_CAL_CTRL;
	fixed_pin_a: assert property (fixedPinCode == FIXED_STRENGTH) else $error("fixed pin code moved");
	ready_high_a: assert property (pready) else $error("pready low");
	no_error_a: assert property (!pslverr) else $error("pslverr high");
	restart_busy_a: assert property (dataWr && pwdata[15] |-> ##2 calBusy [*2]) else $error("no run after restart");
	latch_pmos_a: assert property (dataWr && pwdata[7:5] == 3'b011 && !pwdata[15] |=> pmosCode == $past(pwdata[12:8]))
		else $error("pmos latch lost");
	latch_nmos_a: assert property (dataWr && pwdata[7:5] == 3'b010 && !pwdata[15] |=> nmosCode == $past(pwdata[4:0]))
		else $error("nmos latch lost");
	keep_nmos_a: assert property (dataWr && pwdata[7:5] == 3'b011 && !calBusy |=> $stable(nmosCode))
		else $error("nmos changed on pmos latch");
	keep_pmos_a: assert property (dataWr && pwdata[7:5] == 3'b010 && !calBusy |=> $stable(pmosCode))
		else $error("pmos changed on nmos latch");
	reserved_zero_a: assert property (dataRd |-> prdata[31:16] == 16'h0000 && !prdata[13] && !prdata[7] && !prdata[6])
		else $error("reserved bits nonzero");
endmodule
bind drv_cal drv_cal_chk #(.CODE_WIDTH(CODE_WIDTH)) drv_cal_chk_inst (.mclk, .reset, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .pmosCode, .nmosCode, .fixedPinCode, .calBusy);

// file: dv/test_drv_cal.sv
`timescale 1ns/1ps
module test_drv_cal;
	import drv_cal_pkg::*;
	logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, calBusy, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [4:0] compMeasure = 5'h09, pmosCode, nmosCode, fixedPinCode;
	int num_errors = 0, n_tests = 0;
	drv_cal drv_cal_inst (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.compMeasure, .pmosCode, .nmosCode, .fixedPinCode, .calBusy, .irq);
	initial forever #25 mclk = ~mclk;
	// ---------------------------------------------
	// Bus and compare tasks
	// ---------------------------------------------
	task check(input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; it starts on a rising edge and returns at the falling
	// edge after the access edge, where outputs have settled for the checks
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(negedge mclk);
	endtask
	// Bounded wait; the run length depends on the search distance
	task wait_cal;
		for (int i = 0; i < 2000 && calBusy !== 1'b0; i++) @(negedge mclk);
		check(calBusy, 0);
	endtask
	task close_out;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		reset <= 0;
		check(calBusy, 1);
		wait_cal();
		check({pmosCode, nmosCode}, {5'h09, 5'h09});
		apb(1, 12'h074, 32'h000a);
		apb(0, 12'h078, 0);
		check(rd, 32'h4909);
		apb(0, 12'h080, 0);
		check(rd, 1);
		apb(0, 12'h080, 0);
		check(rd, 0);
		apb(1, 12'h084, 1);
		apb(1, 12'h074, 32'h000b);
		apb(1, 12'h078, 32'h0033);
		apb(0, 12'h078, 0);
		check(rd, 32'h0033);
		apb(1, 12'h074, 32'h000a);
		apb(1, 12'h078, 32'h8000);
		@(negedge mclk);
		check(calBusy, 1);
		apb(0, 12'h078, 0);
		check(rd[15:14], 2'b00);
		wait_cal();
		check({irq, pmosCode, nmosCode}, {1'b1, 5'h08, 5'h08});
		apb(0, 12'h080, 0);
		check({irq, rd}, 33'h1);
		apb(1, 12'h078, 32'h1f65);
		check({pmosCode, nmosCode}, {5'h1f, 5'h08});
		apb(1, 12'h078, 32'h0043);
		check({irq, pmosCode, nmosCode}, {1'b0, 5'h1f, 5'h03});
		apb(0, 12'h078, 0);
		check(rd, 32'h5f03);
		apb(0, 12'h088, 0);
		check({rd, fixedPinCode}, {32'h0, FIXED_STRENGTH});
		// Strongest corner: a goal above the code range must clamp
		@(posedge mclk);
		compMeasure <= 5'h1f;
		apb(1, 12'h074, 32'h000b);
		apb(1, 12'h078, 32'h0000);
		apb(1, 12'h074, 32'h000a);
		apb(1, 12'h078, 32'h8000);
		@(negedge mclk);
		check(calBusy, 1);
		wait_cal();
		check({pmosCode, nmosCode}, {5'h1f, 5'h1f});
		// Second hardware reset reruns calibration with reset targets
		@(posedge mclk);
		reset <= 1;
		repeat (2) @(posedge mclk);
		reset <= 0;
		@(negedge mclk);
		check(calBusy, 1);
		wait_cal();
		check({irq, pmosCode, nmosCode}, {1'b0, 5'h1f, 5'h1f});
		apb(0, 12'h074, 0);
		check(rd, PAGE_RESET);
		close_out();
	end
	// Whole sequence needs well under 2000 cycles
	initial begin
		#(20000 * 50);
		num_errors++;
		close_out();
	end
endmodule
